// file: include/root_port_defs.svh
// Offsets, field positions and sizes for the root port event block
`ifndef ROOT_PORT_DEFS_SVH
`define ROOT_PORT_DEFS_SVH
`define ROOT_CONTROL_OFFSET 8'hbc
`define ROOT_STATUS_OFFSET 8'hc0
`define ADDR_WORD_LSB 2
`define CTL_BE_BIT 0
`define STS_BE_BIT 2
`define STS_RID_MSB 15
`define STS_RID_LSB 0
`define CTL_CORR_BIT 0
`define CTL_NONFATAL_BIT 1
`define CTL_FATAL_BIT 2
`define CTL_PME_INTERRUPT_ENABLE_BIT 3
`define STS_PME_STATUS_FLAG_BIT 16
`define STS_PME_PENDING_FLAG_BIT 17
`define CTL_RESET 4'h0
`define RID_RESET 16'h0000
`define PME_QUEUE_DEPTH 8
`define PME_QUEUE_AW 3
`define PME_COUNT_W 4
`endif

// file: include/root_port_pkg.sv
// Types shared by the root port event block
`default_nettype none
package root_port_pkg;
   typedef struct packed {
      logic fatal;
      logic nonfatal;
      logic correctable;
   } err_event_t;
   typedef struct packed {
      logic valid;
      logic [15:0] rid;
   } pme_msg_t;
   typedef struct packed {
      logic pme_interrupt_enable;
      logic fatal_syserr_enable;
      logic nonfatal_syserr_enable;
      logic correctable_syserr_enable;
   } root_control_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_HELD = 2'b10
   } pme_state_t;
endpackage
`default_nettype wire

// file: rtl/pme_queue.sv
// Arrival-ordered queue of pending PME requester IDs
`timescale 1ns/1ns
`default_nettype none
`include "root_port_defs.svh"
module pme_queue
   import root_port_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic push,
   input wire logic [15:0] push_rid,
   input wire logic pop,
   output logic [15:0] head_rid,
   output logic not_empty,
   output logic full
);
   logic [15:0] mem_q [`PME_QUEUE_DEPTH];
   logic [`PME_QUEUE_AW-1:0] wr_q;
   logic [`PME_QUEUE_AW-1:0] rd_q;
   logic [`PME_COUNT_W-1:0] cnt_q;
   logic do_push;
   logic do_pop;

   assign do_pop = pop && (cnt_q != '0);
   // A full queue drops the newest message rather than overwrite order;
   // a pop in the same cycle frees a slot first
   assign do_push = push && ((cnt_q != `PME_COUNT_W'(`PME_QUEUE_DEPTH)) || do_pop);
   assign head_rid = mem_q[rd_q];
   assign not_empty = (cnt_q != '0);
   assign full = (cnt_q == `PME_COUNT_W'(`PME_QUEUE_DEPTH));

   always_ff @(posedge clk) begin
      if (do_push) begin
         mem_q[wr_q] <= push_rid;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (do_push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (do_pop) begin
            rd_q <= rd_q + 1'b1;
         end
         if (do_push && !do_pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (!do_push && do_pop) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// file: rtl/root_port_pme_serr_control.sv
// Root port PME recording, PME interrupt and system error decision
// Contract
// - Per-severity enables decide system error, overriding command register enable.
// - PME interrupt when enabled and a received PME sets status, or when the enable rises while status is set.
// - Enable rising while status already set also raises PME interrupt.
// - Fatal errors, downstream or local, raise system error when bit 2 set.
// - Non-fatal errors raise system error when bit 1 set.
// - Correctable errors raise system error when bit 0 set.
// - Accepting a PME sets status bit 16; software writes one to clear.
// - Bits 15:0 hold last delivered requester ID, read-only.
// - While status set, further Pme_status_flag stay pending, not delivered.
// - Pending bit 17 set while another PME waits behind status.
// - Clearing status delivers the pending PME: status set, ID loaded.
// - Pending bit clears itself when no Pme_status_flag remain waiting.
`timescale 1ns/1ns
`default_nettype none
`include "root_port_defs.svh"
module root_port_pme_serr_control
   import root_port_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   input wire pme_msg_t pme_msg,
   input wire err_event_t err_msg,
   input wire err_event_t err_local,
   output logic pme_irq,
   output logic serr
);
   // ==========================================================
   // Register decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a[7:`ADDR_WORD_LSB] == off[7:`ADDR_WORD_LSB]);
   endfunction

   // ==========================================================
   // Signals
   root_control_t ctl_q;
   logic pme_status_flag_q;
   logic [15:0] rid_q;
   pme_state_t state_q;
   logic ctl_sel;
   logic sts_sel;
   logic ctl_wr;
   logic sts_clr;
   logic q_push;
   logic q_pop;
   logic [15:0] q_head;
   logic q_ne;
   logic deliver_now;
   logic pme_pending_flag;
   logic ie_rise;
   logic pme_irq_d;
   logic [31:0] rdata_d;
   err_event_t err_all;
   logic fatal_raise;
   logic nonfatal_raise;
   logic corr_raise;

   // Word decode: all byte lanes of a register share its select
   assign ctl_sel = hit(cfg_addr, `ROOT_CONTROL_OFFSET);
   assign sts_sel = hit(cfg_addr, `ROOT_STATUS_OFFSET);
   assign ctl_wr = cfg_wr && ctl_sel && cfg_be[`CTL_BE_BIT];
   assign sts_clr = cfg_wr && sts_sel && cfg_be[`STS_BE_BIT] && cfg_wdata[`STS_PME_STATUS_FLAG_BIT];

   // ==========================================================
   // Root control
   // only bits 3:0 writable
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctl_q <= `CTL_RESET;
      end else if (ctl_wr) begin
         ctl_q <= cfg_wdata[`CTL_PME_INTERRUPT_ENABLE_BIT:`CTL_CORR_BIT];
      end
   end

   // ==========================================================
   // PME acceptance and queue
   // Later messages queue behind older ones so arrival order holds
   // hold new Pme_status_flag while status set or older ones wait
   assign q_push = pme_msg.valid && (pme_status_flag_q || q_ne) && !(sts_clr && !q_ne);
   // Limitation: beyond eight waiting messages the newest is lost
   // in-order pending queue
   pme_queue u_queue (
      .clk(clk),
      .rst(rst),
      .push(q_push),
      .push_rid(pme_msg.rid),
      .pop(q_pop),
      .head_rid(q_head),
      .not_empty(q_ne),
      .full()
   );

   // Direct delivery when nothing waits and status is free
   assign deliver_now = pme_msg.valid && !q_push;
   // pending head delivered once status is free
   assign q_pop = q_ne && (!pme_status_flag_q || sts_clr);
   assign pme_pending_flag = q_ne;

   // ==========================================================
   // PME status flag
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pme_status_flag_q <= 1'b0;
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (q_pop) begin
                  pme_status_flag_q <= 1'b1;
                  state_q <= ST_HELD;
               end else if (deliver_now) begin
                  pme_status_flag_q <= 1'b1;
                  state_q <= ST_HELD;
               end
            end
            ST_HELD: begin
               if (q_pop) begin
                  pme_status_flag_q <= 1'b1;
               end else if (sts_clr && deliver_now) begin
                  // Set wins over clear for the same-cycle message
                  pme_status_flag_q <= 1'b1;
               end else if (sts_clr) begin
                  pme_status_flag_q <= 1'b0;
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               pme_status_flag_q <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rid_q <= `RID_RESET;
      end else if (q_pop) begin
         rid_q <= q_head;
      end else if (deliver_now) begin
         rid_q <= pme_msg.rid;
      end
   end

   // ==========================================================
   // PME interrupt
   // Status is set by a queue pop or by direct delivery
   logic pme_status_flag_set;
   assign pme_status_flag_set = (state_q == ST_IDLE && (q_pop || deliver_now)) || (state_q == ST_HELD
                     && (q_pop || (sts_clr && deliver_now)));
   // enable rising with status already set
   assign ie_rise = ctl_wr && !ctl_q.pme_interrupt_enable && cfg_wdata[`CTL_PME_INTERRUPT_ENABLE_BIT]
                    && pme_status_flag_q;

   // pulse per status setting, only when enabled
   assign pme_irq_d = (ctl_q.pme_interrupt_enable && pme_status_flag_set) || ie_rise;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pme_irq <= 1'b0;
      end else begin
         pme_irq <= pme_irq_d;
      end
   end

   // ==========================================================
   // System error
   // Hierarchy and local errors are treated alike
   assign err_all = err_msg | err_local;
   assign fatal_raise = err_all.fatal && ctl_q.fatal_syserr_enable;
   assign nonfatal_raise = err_all.nonfatal && ctl_q.nonfatal_syserr_enable;
   assign corr_raise = err_all.correctable && ctl_q.correctable_syserr_enable;
   // One pulse per error cycle, not latched
   // severity enables alone decide
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         serr <= 1'b0;
      end else begin
         serr <= fatal_raise || nonfatal_raise || corr_raise;
      end
   end

   // ==========================================================
   // Read data
   // reserved bits zero
   always_comb begin
      rdata_d = '0;
      if (ctl_sel) begin
         rdata_d[`CTL_PME_INTERRUPT_ENABLE_BIT:`CTL_CORR_BIT] = ctl_q;
      end else if (sts_sel) begin
         rdata_d[`STS_RID_MSB:`STS_RID_LSB] = rid_q;
         rdata_d[`STS_PME_STATUS_FLAG_BIT] = pme_status_flag_q;
         rdata_d[`STS_PME_PENDING_FLAG_BIT] = pme_pending_flag;
      end
   end

   // Captured on the read strobe and held until the next read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_rdata <= '0;
      end else if (cfg_rd) begin
         cfg_rdata <= rdata_d;
      end
   end
endmodule
`default_nettype wire

// file: verification/pcie_downstream.sv
// Downstream device model sending PME and error messages
`timescale 1ns/1ns
`default_nettype none
module pcie_downstream
   import root_port_pkg::*;
(
   input wire logic clk,
   output var pme_msg_t pme_msg,
   output var err_event_t err_msg
);
   initial begin
      pme_msg = '0;
      err_msg = '0;
   end
   // Id scrambled after the pulse so a stale value never matches
   task automatic send_pme(input logic [15:0] rid);
      @(posedge clk);
      #1 pme_msg = {1'b1, rid};
      @(posedge clk);
      #1 pme_msg = {1'b0, ~rid};
   endtask
   task automatic send_err(input err_event_t e);
      @(posedge clk);
      #1 err_msg = e;
      @(posedge clk);
      #1 err_msg = '0;
   endtask
endmodule
`default_nettype wire

// file: verification/root_port_pme_serr_control_chk.sv
// Port-level assertions for the root port event block
`timescale 1ns/1ns
`default_nettype none
module root_port_pme_serr_control_chk
   import root_port_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   input wire logic [31:0] cfg_rdata,
   input wire pme_msg_t pme_msg,
   input wire err_event_t err_msg,
   input wire err_event_t err_local,
   input wire logic pme_irq,
   input wire logic serr
);
   // Shadow of control, so serr can be tied to the enables
   logic [3:0] ctl_q;
   logic [2:0] hit;
   assign hit = (err_msg | err_local) & ctl_q[2:0];
   always_ff @(posedge clk or posedge rst) begin
      if (rst) ctl_q <= 4'h0;
      else if (cfg_wr && cfg_addr[7:2] == 6'h2f && cfg_be[0]) ctl_q <= cfg_wdata[3:0];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   serr_on_a: assert property (|hit |=> serr)
      else $error("serr missing");
   serr_cause_a: assert property (serr |-> $past(|hit))
      else $error("serr without enabled error");
   irq_cause_a: assert property (pme_irq |-> $past(pme_msg.valid || cfg_wr))
      else $error("irq without cause");
   irq_off_a: assert property (!ctl_q[3] && !$past(ctl_q[3]) |-> !pme_irq)
      else $error("irq while disabled");
   ctl_read_a: assert property (cfg_rd && !cfg_wr && cfg_addr[7:2] == 6'h2f
      |=> cfg_rdata == {28'h0, ctl_q}) else $error("control readback");
   sts_rsvd_a: assert property (cfg_rd |=> cfg_rdata[31:18] == 14'h0)
      else $error("status reserved bits");
   unmapped_read_a: assert property (cfg_rd && cfg_addr[7:2] != 6'h2f
      && cfg_addr[7:2] != 6'h30 |=> cfg_rdata == 32'h0) else $error("unmapped read");
   pme_status_a: assert property (pme_msg.valid ##1 !cfg_wr ##1 (cfg_rd && !cfg_wr
      && cfg_addr[7:2] == 6'h30) |=> cfg_rdata[16]) else $error("status not set");
   cover property (pme_irq);
   cover property (serr);
   cover property (pme_msg.valid ##1 pme_msg.valid);
endmodule
bind root_port_pme_serr_control root_port_pme_serr_control_chk i_chk (.clk(clk),
   .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
   .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .pme_msg(pme_msg),
   .err_msg(err_msg), .err_local(err_local), .pme_irq(pme_irq), .serr(serr));
`default_nettype wire

// file: verification/root_port_pme_serr_control_test.sv
// Self-checking bench for the root port event block
`timescale 1ns/1ns
`default_nettype none
module root_port_pme_serr_control_test;
   import root_port_pkg::*;
   logic clk, rst, cfg_wr, cfg_rd, serr, pme_irq;
   logic [7:0] cfg_addr;
   logic [3:0] cfg_be;
   logic [31:0] cfg_wdata, cfg_rdata;
   pme_msg_t pme_msg;
   err_event_t err_msg, err_local;
   int failures, compares;
   root_port_pme_serr_control i_root_port_pme_serr_control (.clk(clk), .rst(rst),
      .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .pme_msg(pme_msg),
      .err_msg(err_msg), .err_local(err_local), .pme_irq(pme_irq), .serr(serr));
   pcie_downstream i_pcie_downstream (.clk(clk), .pme_msg(pme_msg), .err_msg(err_msg));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Idle cycle between accesses keeps strobes single-driven per step
   task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      @(posedge clk);
      #1 {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, a, be, d};
      @(posedge clk);
      #1 cfg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      #1 {cfg_rd, cfg_addr} = {1'b1, a};
      @(posedge clk);
      #1 cfg_rd = 1'b0;
      chk("read data", cfg_rdata, exp);
   endtask
   // =====
   // Scenarios
   task automatic t_regs;
      rd(8'hbc, 32'h0);
      rd(8'hc0, 32'h0);
      wr(8'hbc, 4'hf, 32'hffffffff);
      rd(8'hbc, 32'hf);
      rd(8'hc4, 32'h0);
   endtask
   task automatic t_serr;
      err_event_t e;
      for (int i = 0; i < 3; i++) begin
         wr(8'hbc, 4'h1, 32'h1 << i);
         for (int j = 0; j < 6; j++) begin
            e = 3'b001 << (j % 3);
            if (j < 3) i_pcie_downstream.send_err(e);
            else begin
               @(posedge clk);
               #1 err_local = e;
               @(posedge clk);
               #1 err_local = '0;
            end
            chk("serr", serr, i == j % 3);
         end
      end
   endtask
   task automatic t_pme;
      wr(8'hbc, 4'h1, 32'h8);
      i_pcie_downstream.send_pme(16'h1234);
      chk("irq", pme_irq, 1);
      rd(8'hc0, 32'h00011234);
      i_pcie_downstream.send_pme(16'h0abc);
      chk("irq", pme_irq, 0);
      i_pcie_downstream.send_pme(16'h0def);
      wr(8'hc0, 4'hb, 32'hfffeffff);
      rd(8'hc0, 32'h00031234);
      wr(8'hc0, 4'h4, 32'h10000);
      chk("irq", pme_irq, 1);
      rd(8'hc0, 32'h00030abc);
      wr(8'hc0, 4'h4, 32'h10000);
      rd(8'hc0, 32'h00010def);
      wr(8'hc0, 4'h4, 32'h10000);
      rd(8'hc0, 32'h00000def);
   endtask
   task automatic t_rise;
      wr(8'hbc, 4'h1, 32'h0);
      i_pcie_downstream.send_pme(16'h55aa);
      chk("irq", pme_irq, 0);
      wr(8'hbc, 4'h1, 32'h8);
      chk("irq", pme_irq, 1);
      rd(8'hc0, 32'h000155aa);
      fork
         wr(8'hc0, 4'h4, 32'h10000);
         i_pcie_downstream.send_pme(16'h0777);
      join
      chk("irq", pme_irq, 1);
      rd(8'hc0, 32'h00010777);
   endtask
   initial begin
      rst = 1'b1;
      {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata, err_local} = '0;
      repeat (12) @(posedge clk);
      #1 rst = 1'b0;
      t_regs;
      t_serr;
      t_pme;
      t_rise;
      wrap_up;
   end
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      wrap_up;
   end
endmodule
`default_nettype wire
